// >>> core/fcp_consts.svh
`ifndef FCP_CONSTS_SVH
`define FCP_CONSTS_SVH
// mode-select encodings, most significant bit first
`define FCP_MODE_SPI 3'h0
`define FCP_MODE_SPI_EXTENDED_MODE 3'h1
`define FCP_MODE_MSER 3'h4
`define FCP_MODE_SSER 3'h5
`define FCP_MODE_MPAR 3'h6
// clock cycles kept running after wake-up
`define FCP_TAIL_CLOCKS 8'h78
// reset value of the clock divider setting
`define FCP_DIV_RESET 8'h01
`endif

// >>> core/fcp_pkg.sv
package fcp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CLEAR = 3'b001,
    ST_HOLD = 3'b010,
    ST_CONFIG = 3'b011,
    ST_WAKE = 3'b100,
    ST_TAIL = 3'b101,
    ST_USER = 3'b110,
    ST_ERROR = 3'b111
  } fcp_state_type;
endpackage

// >>> core/fcp_ctrl.sv
`timescale 1ns/1ps
`include "fcp_consts.svh"
// Function
// - falling edge on program request enters configuration mode
// - program request ignored while boundary-scan mode is active
// - pull init line low on program request low or power-on release
// - clear memory and hold init low while program request low
// - wait while init line is held low from outside
// - during configuration pull init low on a configuration error
// - pull done low while configuring or completion bit unset
// - release done only with init, request high and bit set
// - stay non-functional while done is held low, if so selected
// - done open-drain by default, optionally actively driven
// - enable dual-purpose pin group of sampled mode at start
// - config clock is output in master modes, input otherwise
// - master clock from internal oscillator, divided by frequency setting
// - master clock runs 120 more cycles after done and wake-up
// - after clock stops, tri-state the pin as an input
// - resume driving clock at next configuration start
// - request toggle restarts serial and parallel only; spi needs power cycle
// - mode bits 000 spi, 001 ext spi, 100/101 serial, 110 parallel
module fcp_ctrl (
  // system
  input wire logic SYS_CLK,
  input wire logic RST,
  // link clock from outside in slave modes
  input wire logic CONFIG_CLOCK_IN,
  // pins
  input wire logic PROGRAM_REQUEST_N,
  input wire logic [2:0] MODE_SELECT,
  input wire logic INIT_STATUS_N_IN,
  output logic INIT_STATUS_N_OUT,
  output logic INIT_STATUS_N_OE,
  input wire logic DONE_IN,
  output logic DONE_OUT,
  output logic DONE_OE,
  output logic CONFIG_CLOCK_OUT,
  output logic CONFIG_CLOCK_OE,
  // engine and option controls
  input wire logic JTAG_ACTIVE,
  input wire logic CONFIG_ERROR,
  input wire logic COMPLETION_BIT,
  input wire logic WAKE_DONE,
  input wire logic DONE_ACTIVE_DRIVE,
  input wire logic WAKE_WAIT_DONE,
  input wire logic [7:0] MASTER_CLOCK_FREQ_PARAM,
  // status
  output logic CLEAR_MEMORY,
  output logic CONFIGURING,
  output logic USER_MODE,
  output logic [2:0] SAMPLED_MODE,
  output logic PIN_GROUP_SPI,
  output logic PIN_GROUP_SERIAL,
  output logic PIN_GROUP_PARALLEL,
  output logic SLAVE_CLOCK_SEEN
);

  // sequencer state; the other registers hang off it or off the pin synchronisers,
  // except the power-on flag, the free-running divider and the link-side toggle
  fcp_pkg::fcp_state_type state_q;
  fcp_pkg::fcp_state_type state_d;
  logic [1:0] prog_s_q;
  logic prog_prev_q;
  logic [1:0] init_s_q;
  logic [1:0] done_s_q;
  logic [2:0] mode_s1_q;
  logic [2:0] mode_s2_q;
  logic [2:0] mode_q;
  logic por_q;
  // decoded request and mode flags, combinational
  logic prog_fall;
  logic prog_low;
  logic is_master;
  logic is_spi;
  // master clock generation and the tail count after wake-up
  logic [7:0] div_cnt_q;
  logic osc_q;
  logic osc_prev_q;
  logic [7:0] tail_cnt_q;
  logic clk_drive_q;
  // link-side toggle and its crossing into the system domain
  logic clk_tog_q;
  logic [2:0] clk_tog_s_q;
  // latched configuration error, shown on the init line
  logic err_q;

  // pins arrive from outside, so every one passes two flip-flops
  // request, init and done reset to their idle high level, so no false
  // edge follows reset; the mode bits reset to zero and are not trusted
  // until the sequencer has let two edges pass
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      prog_s_q <= 2'h3;
      prog_prev_q <= 1'b1;
      init_s_q <= 2'h3;
      done_s_q <= 2'h3;
      mode_s1_q <= 3'h0;
      mode_s2_q <= 3'h0;
    end else begin
      prog_s_q <= {prog_s_q[0], PROGRAM_REQUEST_N};
      prog_prev_q <= prog_s_q[1];
      init_s_q <= {init_s_q[0], INIT_STATUS_N_IN};
      done_s_q <= {done_s_q[0], DONE_IN};
      mode_s1_q <= MODE_SELECT;
      mode_s2_q <= mode_s1_q;
    end
  end

  // request ignored under boundary scan; spi restarts only by power cycle
  assign prog_low = ~prog_s_q[1] & ~JTAG_ACTIVE & ~is_spi;
  assign prog_fall = prog_prev_q & prog_low;
  assign is_spi = (mode_q == `FCP_MODE_SPI) || (mode_q == `FCP_MODE_SPI_EXTENDED_MODE);
  assign is_master = is_spi || (mode_q == `FCP_MODE_MSER) ||
                     (mode_q == `FCP_MODE_MPAR);

  // power-on flag: high for the first edge after reset release
  // the sequencer stays idle while it is high, which gives the mode
  // synchroniser time to fill before the mode is captured
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      por_q <= 1'b1;
    end else begin
      por_q <= 1'b0;
    end
  end

  // sequencer
  // clear and hold follow the request pin; configuration waits for the
  // init line; error and user mode are left only by a new request fall
  // a restart from any state is applied last so it always wins
  always_comb begin
    state_d = state_q;
    case (state_q)
      fcp_pkg::ST_IDLE: begin
        // wait one edge so the synchronised mode is valid in clear
        if (!por_q) begin
          state_d = fcp_pkg::ST_CLEAR;
        end
      end
      fcp_pkg::ST_CLEAR: begin
        if (!prog_low) begin
          state_d = fcp_pkg::ST_HOLD;
        end
      end
      fcp_pkg::ST_HOLD: begin
        if (prog_low) begin
          state_d = fcp_pkg::ST_CLEAR;
        end else if (init_s_q[1]) begin
          state_d = fcp_pkg::ST_CONFIG;
        end
      end
      fcp_pkg::ST_CONFIG: begin
        if (CONFIG_ERROR) begin
          state_d = fcp_pkg::ST_ERROR;
        end else if (COMPLETION_BIT) begin
          state_d = fcp_pkg::ST_WAKE;
        end
      end
      fcp_pkg::ST_WAKE: begin
        // external hold on done delays wake-up when so selected
        if (WAKE_DONE && (done_s_q[1] || !WAKE_WAIT_DONE)) begin
          state_d = fcp_pkg::ST_TAIL;
        end
      end
      fcp_pkg::ST_TAIL: begin
        if (tail_cnt_q == 8'h00 || !is_master) begin
          state_d = fcp_pkg::ST_USER;
        end
      end
      fcp_pkg::ST_USER: begin
        state_d = fcp_pkg::ST_USER;
      end
      fcp_pkg::ST_ERROR: begin
        state_d = fcp_pkg::ST_ERROR;
      end
      default: begin
        state_d = fcp_pkg::ST_IDLE;
      end
    endcase
    // a new falling request restarts from any state
    if (prog_fall) begin
      state_d = fcp_pkg::ST_CLEAR;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_q <= fcp_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // mode captured on every edge in clear, held from then until the next start
  // captured in clear only: at power-on the synchroniser is full by then,
  // and on a request the pins have been stable for at least two edges
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      mode_q <= 3'h0;
    end else if (state_q == fcp_pkg::ST_CLEAR) begin
      mode_q <= mode_s2_q;
    end
  end

  // error flag for the init line; latched until restart
  // a restart and an error cannot meet: an error is only taken in the
  // configuration state, a clear only in the clear state
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      err_q <= 1'b0;
    end else if (state_q == fcp_pkg::ST_CLEAR) begin
      err_q <= 1'b0;
    end else if (state_q == fcp_pkg::ST_CONFIG && CONFIG_ERROR) begin
      err_q <= 1'b1;
    end
  end

  // oscillator divider: half period is the frequency setting plus one
  // the divider runs free; only the drive window gates it onto the pin,
  // so a slower setting stretches only the tail phase of the sequence
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      div_cnt_q <= 8'h00;
      osc_q <= 1'b0;
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_q;
      if (div_cnt_q >= MASTER_CLOCK_FREQ_PARAM) begin
        div_cnt_q <= 8'h00;
        osc_q <= ~osc_q;
      end else begin
        div_cnt_q <= div_cnt_q + 8'h01;
      end
    end
  end

  // clock drive window: starts at each initialization, stops after tail
  // the tail counts oscillator rises, not system edges, so the number of
  // extra clocks seen by chained devices does not depend on the divider
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      clk_drive_q <= 1'b0;
      tail_cnt_q <= `FCP_TAIL_CLOCKS;
    end else begin
      if (state_q == fcp_pkg::ST_CLEAR) begin
        clk_drive_q <= 1'b1;
        tail_cnt_q <= `FCP_TAIL_CLOCKS;
      end else if (state_q == fcp_pkg::ST_TAIL) begin
        // count rising edges of the driven clock
        if (osc_q && !osc_prev_q && tail_cnt_q != 8'h00) begin
          tail_cnt_q <= tail_cnt_q - 8'h01;
        end
      end else if (state_q == fcp_pkg::ST_USER) begin
        clk_drive_q <= 1'b0;
      end
    end
  end

  // slave clock activity: a toggle in the link domain, crossed by sync
  // only one bit crosses, so no handshake is needed; a link clock faster
  // than the system clock would hide some of its edges
  always_ff @(posedge CONFIG_CLOCK_IN or posedge RST) begin
    if (RST) begin
      clk_tog_q <= 1'b0;
    end else begin
      clk_tog_q <= ~clk_tog_q;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      clk_tog_s_q <= 3'h0;
      SLAVE_CLOCK_SEEN <= 1'b0;
    end else begin
      clk_tog_s_q <= {clk_tog_s_q[1:0], clk_tog_q};
      SLAVE_CLOCK_SEEN <= clk_tog_s_q[2] ^ clk_tog_s_q[1];
    end
  end

  // pin drivers
  // every pin control is registered so the pads never see decode glitches
  // init is open drain: its data is always low and only the enable moves
  // done is released only once init and request are seen high
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      INIT_STATUS_N_OUT <= 1'b0;
      INIT_STATUS_N_OE <= 1'b1;
      DONE_OUT <= 1'b0;
      DONE_OE <= 1'b1;
      CONFIG_CLOCK_OUT <= 1'b0;
      CONFIG_CLOCK_OE <= 1'b0;
    end else begin
      INIT_STATUS_N_OUT <= 1'b0;
      // open drain: drive only the low level
      INIT_STATUS_N_OE <= (state_q == fcp_pkg::ST_IDLE) ||
                          (state_q == fcp_pkg::ST_CLEAR) || err_q;
      if ((state_q == fcp_pkg::ST_WAKE || state_q == fcp_pkg::ST_TAIL ||
           state_q == fcp_pkg::ST_USER) && COMPLETION_BIT &&
          init_s_q[1] && prog_s_q[1]) begin
        DONE_OUT <= 1'b1;
        DONE_OE <= DONE_ACTIVE_DRIVE;
      end else begin
        DONE_OUT <= 1'b0;
        DONE_OE <= 1'b1;
      end
      CONFIG_CLOCK_OUT <= osc_q & clk_drive_q & is_master;
      CONFIG_CLOCK_OE <= clk_drive_q & is_master;
    end
  end

  // status and pin-group enables
  // unknown mode codes enable no pin group, so those pins stay idle
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      CLEAR_MEMORY <= 1'b1;
      CONFIGURING <= 1'b0;
      USER_MODE <= 1'b0;
      SAMPLED_MODE <= 3'h0;
      PIN_GROUP_SPI <= 1'b0;
      PIN_GROUP_SERIAL <= 1'b0;
      PIN_GROUP_PARALLEL <= 1'b0;
    end else begin
      CLEAR_MEMORY <= (state_q == fcp_pkg::ST_CLEAR) ||
                      (state_q == fcp_pkg::ST_IDLE);
      CONFIGURING <= (state_q == fcp_pkg::ST_CONFIG);
      USER_MODE <= (state_q == fcp_pkg::ST_USER);
      SAMPLED_MODE <= mode_q;
      PIN_GROUP_SPI <= is_spi;
      PIN_GROUP_SERIAL <= (mode_q == `FCP_MODE_MSER) ||
                          (mode_q == `FCP_MODE_SSER);
      PIN_GROUP_PARALLEL <= (mode_q == `FCP_MODE_MPAR);
    end
  end

endmodule

// >>> testbench/fcp_ctrl_props.sv
`timescale 1ns/1ps
module fcp_ctrl_props (
  // system
  input wire logic SYS_CLK,
  input wire logic RST,
  // pins
  input wire logic PROGRAM_REQUEST_N,
  input wire logic INIT_STATUS_N_IN,
  input wire logic INIT_STATUS_N_OUT,
  input wire logic INIT_STATUS_N_OE,
  input wire logic DONE_OUT,
  input wire logic DONE_OE,
  input wire logic CONFIG_CLOCK_OE,
  // controls and status
  input wire logic JTAG_ACTIVE,
  input wire logic CONFIG_ERROR,
  input wire logic COMPLETION_BIT,
  input wire logic CLEAR_MEMORY,
  input wire logic CONFIGURING,
  input wire logic USER_MODE,
  input wire logic [2:0] SAMPLED_MODE,
  input wire logic PIN_GROUP_SERIAL
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // done counts as released unless it is pulled low
  wire done_rel = !(DONE_OE && !DONE_OUT);
  init_hold_a: assert property ((!PROGRAM_REQUEST_N && !JTAG_ACTIVE &&
    SAMPLED_MODE[2])[*6] |-> INIT_STATUS_N_OE)
    else $error("init line not held low during request");
  init_drain_a: assert property (!INIT_STATUS_N_OUT)
    else $error("init line driven high");
  error_flag_a: assert property (CONFIGURING && CONFIG_ERROR
    |-> ##[1:3] INIT_STATUS_N_OE) else $error("error not flagged on init");
  done_low_a: assert property (CONFIGURING && !COMPLETION_BIT
    |-> !done_rel) else $error("done released while configuring");
  done_rise_a: assert property ($rose(done_rel) |-> COMPLETION_BIT &&
    PROGRAM_REQUEST_N && INIT_STATUS_N_IN) else $error("early done release");
  clock_master_a: assert property (CONFIGURING && CONFIG_CLOCK_OE
    |-> SAMPLED_MODE inside {3'h0, 3'h1, 3'h4, 3'h6})
    else $error("clock driven in slave mode");
  clock_stop_a: assert property (USER_MODE && $past(USER_MODE)
    |-> !CONFIG_CLOCK_OE) else $error("clock still driven in user mode");
  mode_hold_a: assert property (CONFIGURING && $past(CONFIGURING)
    |-> $stable(SAMPLED_MODE)) else $error("mode changed mid-configuration");
  serial_group_a: assert property (PIN_GROUP_SERIAL && CONFIGURING
    |-> SAMPLED_MODE[2:1] == 2'b10) else $error("wrong pin group");
endmodule
bind fcp_ctrl fcp_ctrl_props u_fcp_ctrl_props (.SYS_CLK, .RST,
  .PROGRAM_REQUEST_N, .INIT_STATUS_N_IN, .INIT_STATUS_N_OUT,
  .INIT_STATUS_N_OE, .DONE_OUT, .DONE_OE, .CONFIG_CLOCK_OE, .JTAG_ACTIVE,
  .CONFIG_ERROR, .COMPLETION_BIT, .CLEAR_MEMORY, .CONFIGURING, .USER_MODE,
  .SAMPLED_MODE, .PIN_GROUP_SERIAL);

// >>> testbench/fcp_far_model.sv
`timescale 1ns/1ps
module fcp_far_model (
  // bench controls
  input wire logic hold_init,
  input wire logic hold_done,
  input wire logic run_clk,
  // device drives
  input wire logic init_oe,
  input wire logic done_out,
  input wire logic done_oe,
  input wire logic clk_out,
  input wire logic clk_oe,
  // resolved pins
  output logic init_pin,
  output logic done_pin,
  output logic clk_pin
);
  logic ext_clk = 1'b0;
  // slave source stands low when not asked to run
  always #15 ext_clk = run_clk ? !ext_clk : 1'b0;
  // parallel chip-selects stand high on the board, outside this model
  // pull-ups: any party pulling low wins
  assign init_pin = !(init_oe || hold_init);
  assign done_pin = (done_oe ? done_out : 1'b1) && !hold_done;
  assign clk_pin = clk_oe ? clk_out : ext_clk;
endmodule

// >>> testbench/tb_fcp_ctrl.sv
`timescale 1ns/1ps
`include "fcp_consts.svh"
module tb_fcp_ctrl;
  logic clk, rst, prn, jtag, cerr, cbit, wdone, dad, wwd, hi, hd, rc;
  logic init_oe, init_o, init_pin, done_o, done_oe, done_pin, ck_o, ck_oe;
  logic ck_pin, clr, cfg, usr, seen, g_spi, g_ser, g_par;
  logic [2:0] mode, smode;
  int fail_count = 0;
  int checked = 0;
  int n;
  fcp_ctrl u_fcp_ctrl (.SYS_CLK(clk), .RST(rst), .CONFIG_CLOCK_IN(ck_pin),
    .PROGRAM_REQUEST_N(prn), .MODE_SELECT(mode), .INIT_STATUS_N_IN(init_pin),
    .INIT_STATUS_N_OUT(init_o), .INIT_STATUS_N_OE(init_oe),
    .DONE_IN(done_pin), .DONE_OUT(done_o), .DONE_OE(done_oe),
    .CONFIG_CLOCK_OUT(ck_o), .CONFIG_CLOCK_OE(ck_oe), .JTAG_ACTIVE(jtag),
    .CONFIG_ERROR(cerr), .COMPLETION_BIT(cbit), .WAKE_DONE(wdone),
    .DONE_ACTIVE_DRIVE(dad), .WAKE_WAIT_DONE(wwd),
    .MASTER_CLOCK_FREQ_PARAM(8'h07), .CLEAR_MEMORY(clr), .CONFIGURING(cfg),
    .USER_MODE(usr), .SAMPLED_MODE(smode), .PIN_GROUP_SPI(g_spi),
    .PIN_GROUP_SERIAL(g_ser), .PIN_GROUP_PARALLEL(g_par),
    .SLAVE_CLOCK_SEEN(seen));
  fcp_far_model u_fcp_far_model (.hold_init(hi), .hold_done(hd),
    .run_clk(rc), .init_oe(init_oe), .done_out(done_o), .done_oe(done_oe),
    .clk_out(ck_o), .clk_oe(ck_oe), .init_pin(init_pin),
    .done_pin(done_pin), .clk_pin(ck_pin));
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: saw %h wanted %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // bounded wait: 0 configuring, 1 user mode, 2 link clock seen
  task automatic wait_hi(input int sel);
    int i;
    for (i = 0; i < 4000; i++) begin
      if ((sel == 0 ? cfg : sel == 1 ? usr : seen) === 1'b1) break;
      cyc(1);
    end
    if (i == 4000) begin
      fail_count++;
      give_verdict();
    end
  endtask
  // counts master clock rises, stops when the pin is let go
  task automatic edges(input int k, input bit one);
    logic prev;
    prev = ck_o;
    n = 0;
    repeat (k) begin
      cyc(1);
      if (ck_o === 1'b1 && prev === 1'b0) n++;
      prev = ck_o;
      if ((one && n > 0) || ck_oe !== 1'b1) break;
    end
  endtask
  task automatic req_pulse;
    prn = 1'b0;
    cyc(10);
    prn = 1'b1;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  initial begin
    {rst, prn, jtag, cerr, cbit, wdone, dad, wwd, hi, hd, rc} = 11'h600;
    mode = `FCP_MODE_MSER;
    cyc(12);
    rst = 1'b0;
    wait_hi(0);
    chk(init_oe, 1'h0);
    chk(done_oe && !done_o, 1'h1);
    chk(smode, `FCP_MODE_MSER);
    chk(g_ser, 1'h1);
    edges(64, 1'b0);
    chk(n[7:0], 8'h04);
    $display("test power_on done");
    cerr = 1'b1;
    cyc(4);
    chk(init_oe, 1'h1);
    cerr = 1'b0;
    hi = 1'b1;
    prn = 1'b0;
    cyc(10);
    chk({init_oe, clr}, 2'h3);
    prn = 1'b1;
    cyc(30);
    chk(cfg, 1'h0);
    hi = 1'b0;
    wait_hi(0);
    chk(cfg, 1'h1);
    $display("test error_restart done");
    {wwd, hd, cbit, wdone} = 4'hf;
    cyc(30);
    chk({done_oe, done_o}, 2'h1);
    chk(usr, 1'h0);
    edges(40, 1'b1);
    hd = 1'b0;
    edges(3000, 1'b0);
    chk(n[7:0], `FCP_TAIL_CLOCKS);
    wait_hi(1);
    chk(ck_oe, 1'h0);
    req_pulse;
    cyc(20);
    chk({ck_oe, usr}, 2'h2);
    wait_hi(1);
    $display("test wake_tail done");
    mode = `FCP_MODE_SSER;
    {dad, rc} = 2'h3;
    cyc(5);
    chk(smode, `FCP_MODE_MSER);
    req_pulse;
    wait_hi(2);
    wait_hi(1);
    chk(smode, `FCP_MODE_SSER);
    chk(ck_oe, 1'h0);
    chk({done_oe, done_o}, 2'h3);
    jtag = 1'b1;
    req_pulse;
    cyc(10);
    chk(usr, 1'h1);
    jtag = 1'b0;
    $display("test slave_jtag done");
    mode = `FCP_MODE_MPAR;
    req_pulse;
    wait_hi(1);
    chk(smode, `FCP_MODE_MPAR);
    chk({g_par, g_ser, g_spi}, 3'h4);
    $display("test parallel done");
    mode = `FCP_MODE_SPI;
    req_pulse;
    cyc(8);
    chk(usr, 1'h0);
    wait_hi(1);
    chk(smode, `FCP_MODE_SPI);
    chk({g_par, g_ser, g_spi}, 3'h1);
    req_pulse;
    cyc(10);
    chk(usr, 1'h1);
    $display("test spi_lock done");
    give_verdict();
  end
endmodule
